// ===== edx_pkg.sv
// Package of constants and types for the external data access unit.
// Assumes a classic Wishbone slave port with 32-bit data and one clock.
//
// What this block does
// - A register-indirect access takes its low address byte from the chosen work register of the active bank and its high byte from the port 2 latch.
// - A pointer-indirect access drives all sixteen address bits from the selected data pointer.
// - Two data pointers exist and bit 0 of the pointer select register at 86h picks the second when set.
// - The upper seven bits of the pointer select register have no effect and always read as zero.
// - Every external move starts with a normal four-clock fetch cycle and the address and access come in the next machine cycle.
// - A three-bit stretch field in bits 2 to 0 of the clock control register gives external moves of 2 to 9 machine cycles.
// - The strobe is 2 clocks wide for stretch 0 and four clocks per stretch step otherwise.
// - The stretch field resets to 1 for a three machine cycle move and software may write 0 for two cycles.
// - Only external moves are lengthened, by holding the processor for every access cycle after the fetch cycle.
// - Each machine cycle is four clock states C1 to C4 and all access counts are in such cycles.
package edx_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FIRST_PTR = 8'h82;
  localparam logic [7:0] IDX_SECOND_PTR = 8'h84;
  localparam logic [7:0] IDX_PTR_SELECT = 8'h86;
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'h8e;
  localparam logic [7:0] IDX_PORT2 = 8'ha0;
  localparam logic [7:0] IDX_BANK_SEL = 8'hd0;
  localparam logic [7:0] IDX_XFER_CMD = 8'hf0;
  localparam logic [7:0] IDX_XFER_WDATA = 8'hf1;
  localparam logic [7:0] IDX_XFER_STATUS = 8'hf2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BANK_LSB = 3;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_PTR_BIT = 1;
  localparam int CMD_RI_BIT = 2;
  localparam logic [2:0] STRETCH_RST = 3'h1;
  localparam logic [7:0] PORT2_RST = 8'hff;

  // ----------------------------------------------------------------
  // Timing counts in clocks
  // ----------------------------------------------------------------
  localparam logic [1:0] STATES_LAST = 2'h3;
  localparam logic [4:0] STROBE_LO_FAST = 5'h01;
  localparam logic [4:0] STROBE_LO_SLOW = 5'h02;
  localparam logic [4:0] STROBE_W_FAST = 5'h02;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_ACCESS = 3'h4
  } edx_state_e;

  typedef struct packed {
    logic write;
    logic use_ptr;
    logic ri;
  } edx_cmd_s;

endpackage

// ===== edx_access.sv
// External data access unit: address forming, pointers and stretched
// read/write strobes, with its registers on a classic Wishbone slave.
// Assumes one clock (CLK) and an asynchronous active-high RESET.
`timescale 1ns/1ns
module edx_access (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [15:0] EXT_ADDR,
  output logic EXT_RD_N,
  output logic EXT_WR_N,
  output logic [7:0] EXT_DOUT,
  output logic EXT_DOE,
  input wire logic [7:0] EXT_DIN,
  output logic [1:0] CLOCK_STATE,
  output logic FETCH_CYCLE,
  output logic CPU_HOLD
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // First strobe clock within the access phase
  function automatic logic [4:0] strobe_lo(input logic [2:0] s);
    strobe_lo = (s == 3'h0) ? edx_pkg::STROBE_LO_FAST
                            : edx_pkg::STROBE_LO_SLOW;
  endfunction

  // Strobe width in clocks
  function automatic logic [4:0] strobe_w(input logic [2:0] s);
    strobe_w = (s == 3'h0) ? edx_pkg::STROBE_W_FAST : {s, 2'b00};
  endfunction

  // Strobe active at this access clock
  function automatic logic in_strobe(input logic [4:0] c,
                                     input logic [2:0] s);
    logic [5:0] hi;
    hi = {1'b0, strobe_lo(s)} + {1'b0, strobe_w(s)};
    in_strobe = (c >= strobe_lo(s)) && ({1'b0, c} < hi);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  edx_pkg::edx_state_e state_r;
  edx_pkg::edx_cmd_s cmd_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [15:0] first_ptr_r;
  logic [15:0] second_ptr_r;
  logic ptr_sel_r;
  logic [2:0] stretch_r;
  logic [7:0] ctrl_hi_r;
  logic [7:0] port2_r;
  logic [1:0] bank_r;
  logic [7:0] work_r [0:7];
  logic [7:0] wdata_r;
  logic [7:0] rddata_r;
  logic pend_r;
  logic [2:0] xstretch_r;
  logic [4:0] cnt_r;
  logic [1:0] phase_r;
  logic [15:0] addr_r;
  logic rd_n_r;
  logic wr_n_r;
  logic doe_r;
  logic [7:0] dout_r;
  logic access;
  logic wr_acc;
  logic [7:0] idx;
  logic [4:0] last_cnt;
  logic strobe_nxt;
  logic [15:0] addr_nxt;
  logic [2:0] work_sel;

  // Decoded bus request, taken once per handshake
  assign access = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_acc = access && WB_WE_I && WB_SEL_I[0];
  assign idx = WB_ADR_I[9:2];
  assign last_cnt = {xstretch_r, 2'b11};
  assign work_sel = {bank_r, cmd_r.ri};

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One-cycle acknowledge, dropped in the next cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  // Read mux; unmapped indices read as zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= 32'h0;
    end else if (access) begin
      rdata_r <= 32'h0;
      unique case (idx)
        edx_pkg::IDX_FIRST_PTR: rdata_r <= {16'h0, first_ptr_r};
        edx_pkg::IDX_SECOND_PTR: rdata_r <= {16'h0, second_ptr_r};
        edx_pkg::IDX_PTR_SELECT: rdata_r <= {31'h0, ptr_sel_r};
        edx_pkg::IDX_CLOCK_CTRL: rdata_r <= {24'h0, ctrl_hi_r[7:3],
                                             stretch_r};
        edx_pkg::IDX_PORT2: rdata_r <= {24'h0, port2_r};
        edx_pkg::IDX_BANK_SEL: rdata_r <= {27'h0, bank_r, 3'h0};
        edx_pkg::IDX_XFER_CMD: rdata_r <= {29'h0, cmd_r};
        edx_pkg::IDX_XFER_WDATA: rdata_r <= {24'h0, wdata_r};
        edx_pkg::IDX_XFER_STATUS: begin // Busy through fetch and access
          rdata_r <= {16'h0, rddata_r, 7'h0,
                      pend_r || state_r != edx_pkg::ST_IDLE};
        end
        default: begin
          if (idx[7:5] == 3'h0 && idx[2:1] == 2'h0) begin
            rdata_r <= {24'h0, work_r[{idx[4:3], idx[0]}]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data pointers and pointer select
  // ----------------------------------------------------------------
  // Two 16-bit pointers, byte lanes 0 and 1
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      first_ptr_r <= 16'h0;
      second_ptr_r <= 16'h0;
    end else if (access && WB_WE_I) begin
      if (idx == edx_pkg::IDX_FIRST_PTR) begin
        if (WB_SEL_I[0]) first_ptr_r[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) first_ptr_r[15:8] <= WB_DAT_I[15:8];
      end
      if (idx == edx_pkg::IDX_SECOND_PTR) begin
        if (WB_SEL_I[0]) second_ptr_r[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) second_ptr_r[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // Only bit 0 is stored; the upper seven stay zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ptr_sel_r <= 1'b0;
    end else if (wr_acc && idx == edx_pkg::IDX_PTR_SELECT) begin
      ptr_sel_r <= WB_DAT_I[0];
    end
  end

  // ----------------------------------------------------------------
  // Clock control, port 2 latch, bank and work registers
  // ----------------------------------------------------------------
  // Stretch field in bits 2..0, other bits plain storage
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stretch_r <= edx_pkg::STRETCH_RST;
      ctrl_hi_r <= 8'h0;
    end else if (wr_acc && idx == edx_pkg::IDX_CLOCK_CTRL) begin
      stretch_r <= WB_DAT_I[2:0];
      ctrl_hi_r <= {WB_DAT_I[7:3], 3'h0};
    end
  end

  // Port 2 latch and active bank
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      port2_r <= edx_pkg::PORT2_RST;
      bank_r <= 2'h0;
    end else if (wr_acc) begin
      if (idx == edx_pkg::IDX_PORT2) port2_r <= WB_DAT_I[7:0];
      if (idx == edx_pkg::IDX_BANK_SEL) begin
        bank_r <= WB_DAT_I[edx_pkg::BANK_LSB +: 2];
      end
    end
  end

  // R0 and R1 of each of the four banks
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 8; i++) work_r[i] <= 8'h0;
    end else if (wr_acc && idx[7:5] == 3'h0 && idx[2:1] == 2'h0) begin
      work_r[{idx[4:3], idx[0]}] <= WB_DAT_I[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transfer command and write data
  // ----------------------------------------------------------------
  // A command is taken only while no transfer is pending or running
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cmd_r <= '0;
      pend_r <= 1'b0;
      wdata_r <= 8'h0;
    end else begin
      if (wr_acc && idx == edx_pkg::IDX_XFER_WDATA) begin
        wdata_r <= WB_DAT_I[7:0];
      end
      if (wr_acc && idx == edx_pkg::IDX_XFER_CMD && !pend_r &&
          state_r == edx_pkg::ST_IDLE) begin
        cmd_r.write <= WB_DAT_I[edx_pkg::CMD_WRITE_BIT];
        cmd_r.use_ptr <= WB_DAT_I[edx_pkg::CMD_PTR_BIT];
        cmd_r.ri <= WB_DAT_I[edx_pkg::CMD_RI_BIT];
        pend_r <= 1'b1;
      end else if (state_r == edx_pkg::ST_IDLE &&
                   phase_r == edx_pkg::STATES_LAST) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle states and sequencer
  // ----------------------------------------------------------------
  // Free-running C1..C4 state counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Idle, fetch cycle, then stretched access cycles
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= edx_pkg::ST_IDLE;
      cnt_r <= 5'h0;
      xstretch_r <= edx_pkg::STRETCH_RST;
    end else begin
      unique case (state_r)
        edx_pkg::ST_IDLE: begin
          if (pend_r && phase_r == edx_pkg::STATES_LAST) begin
            state_r <= edx_pkg::ST_FETCH;
            xstretch_r <= stretch_r;
          end
        end
        edx_pkg::ST_FETCH: begin
          cnt_r <= 5'h0;
          if (phase_r == edx_pkg::STATES_LAST) begin
            state_r <= edx_pkg::ST_ACCESS;
          end
        end
        edx_pkg::ST_ACCESS: begin
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r == last_cnt) begin
            state_r <= edx_pkg::ST_IDLE;
          end
        end
        default: state_r <= edx_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------
  // Address source and strobe window for the next clock
  always_comb begin
    if (cmd_r.use_ptr) begin
      addr_nxt = ptr_sel_r ? second_ptr_r : first_ptr_r;
    end else begin
      addr_nxt = {port2_r, work_r[work_sel]};
    end
    strobe_nxt = 1'b0;
    if (state_r == edx_pkg::ST_ACCESS && cnt_r != last_cnt) begin
      strobe_nxt = in_strobe(cnt_r + 5'h1, xstretch_r);
    end
  end

  // Address, strobes and data drive, all registered
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      addr_r <= 16'h0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      doe_r <= 1'b0;
      dout_r <= 8'h0;
    end else begin
      if (state_r == edx_pkg::ST_FETCH &&
          phase_r == edx_pkg::STATES_LAST) begin
        addr_r <= addr_nxt;
        dout_r <= wdata_r;
      end
      rd_n_r <= !(strobe_nxt && !cmd_r.write);
      wr_n_r <= !(strobe_nxt && cmd_r.write);
      if (state_r == edx_pkg::ST_FETCH &&
          phase_r == edx_pkg::STATES_LAST) begin
        doe_r <= cmd_r.write;
      end else if (state_r == edx_pkg::ST_ACCESS && cnt_r == last_cnt) begin
        doe_r <= 1'b0;
      end
    end
  end

  // Read data caught on the last clock of the read strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rddata_r <= 8'h0;
    end else if (state_r == edx_pkg::ST_ACCESS && !rd_n_r &&
                 !strobe_nxt) begin
      rddata_r <= EXT_DIN;
    end
  end

  // ----------------------------------------------------------------
  // Output assignments, all straight from flip-flops
  // ----------------------------------------------------------------
  assign WB_DAT_O = rdata_r;
  assign WB_ACK_O = ack_r;
  assign EXT_ADDR = addr_r;
  assign EXT_RD_N = rd_n_r;
  assign EXT_WR_N = wr_n_r;
  assign EXT_DOUT = dout_r;
  assign EXT_DOE = doe_r;
  assign CLOCK_STATE = phase_r;
  assign FETCH_CYCLE = state_r[1];
  assign CPU_HOLD = state_r[2];

endmodule

// ===== edx_access_asserts.sv
// Checker for the external data access unit, bound to its top module.
// Assumes one clock CLK and an active-high asynchronous RESET.
`timescale 1ns/1ns
module edx_access_asserts (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic WB_ACK_O,
  input wire logic [15:0] EXT_ADDR,
  input wire logic EXT_RD_N,
  input wire logic EXT_WR_N,
  input wire logic [7:0] EXT_DOUT,
  input wire logic EXT_DOE,
  input wire logic [1:0] CLOCK_STATE,
  input wire logic FETCH_CYCLE,
  input wire logic CPU_HOLD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [4:0] low_r;
  // ----
  // Strobe width
  // ----
  // Counts clocks of the active strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET || (EXT_RD_N && EXT_WR_N)) begin
      low_r <= 5'h00;
    end else begin
      low_r <= low_r + 5'h01;
    end
  end
  // ----
  // Properties
  // ----
  a_ack_answers: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=>
    WB_ACK_O) else $error("request not acked");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_state_step: assert property (!$past(RESET) |->
    CLOCK_STATE == $past(CLOCK_STATE) + 2'h1) else $error("bad state");
  a_fetch_first: assert property ($rose(FETCH_CYCLE) |->
    CLOCK_STATE == 2'h0 ##1 FETCH_CYCLE [*3] ##1 !FETCH_CYCLE && CPU_HOLD)
    else $error("fetch cycle wrong");
  a_hold_whole: assert property ($rose(CPU_HOLD) || $fell(CPU_HOLD) |->
    CLOCK_STATE == 2'h0) else $error("hold not machine cycles");
  a_strobe_held: assert property (!(EXT_RD_N && EXT_WR_N) |->
    CPU_HOLD && EXT_RD_N != EXT_WR_N) else $error("strobe outside hold");
  a_strobe_late: assert property ($fell(EXT_RD_N) || $fell(EXT_WR_N) |->
    $past(CPU_HOLD)) else $error("strobe before address");
  a_strobe_width: assert property ($rose(EXT_RD_N) || $rose(EXT_WR_N) |->
    low_r == 5'h02 || (low_r[1:0] == 2'h0 && low_r <= 5'h1c))
    else $error("strobe width");
  a_wdata_stable: assert property (!EXT_WR_N |-> EXT_DOE &&
    $stable(EXT_DOUT) && $stable(EXT_ADDR)) else $error("write data moved");
  a_addr_hold: assert property (CPU_HOLD && $past(CPU_HOLD) |->
    $stable(EXT_ADDR)) else $error("address moved");
  c_read: cover property ($rose(EXT_RD_N));
  c_write: cover property ($rose(EXT_WR_N));
  c_reg_write: cover property (WB_ACK_O && WB_WE_I);
endmodule
bind edx_access edx_access_asserts u_chk (.CLK(CLK), .RESET(RESET),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ACK_O(WB_ACK_O), .EXT_ADDR(EXT_ADDR), .EXT_RD_N(EXT_RD_N),
  .EXT_WR_N(EXT_WR_N), .EXT_DOUT(EXT_DOUT), .EXT_DOE(EXT_DOE),
  .CLOCK_STATE(CLOCK_STATE), .FETCH_CYCLE(FETCH_CYCLE),
  .CPU_HOLD(CPU_HOLD));

// ===== edx_xmem_model.sv
// Behavioural off-chip data memory for the access unit bench.
// Assumes active-low strobes and one shared clock.
`timescale 1ns/1ns
module edx_xmem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] wdata,
  input wire logic doe,
  output logic [7:0] rdata
);
  logic [7:0] mem_r [256];
  logic [7:0] last_r = 8'h5a;
  logic [7:0] key;
  logic lo_r = 1'b0;
  // Both address bytes pick the cell
  assign key = addr[7:0] ^ addr[15:8];
  // Stores write data while the write strobe is low
  always_ff @(posedge clk) begin
    if (!wr_n && doe) begin
      mem_r[key] <= wdata;
    end
    lo_r <= !rd_n;
    last_r <= rdata;
  end
  // Slow mode withholds data for the first strobe clock; off the
  // strobe the line shows a pattern that changes every clock
  assign rdata = (!rd_n && (!slow || lo_r)) ? mem_r[key] : ~last_r;
endmodule

// ===== tb_top.sv
// Testbench: register and transfer sequences against the access unit.
// Assumes the design module edx_access and the memory model.
`timescale 1ns/1ns
module tb_top;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic [11:2] adr = 10'h000;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, sc;
  logic ack, rd_n, wr_n, doe, fetch, hold;
  logic [1:0] cs;
  logic [7:0] xo, xi, rb, dt;
  logic [15:0] xa, ad, ad_q;
  logic [7:0] rix [5] = '{8'h82, 8'h84, 8'h86, 8'h8e, 8'ha0};
  logic [31:0] rvl [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'hff};
  int n_mismatch = 0;
  int compares = 0;
  int st_n, ho_n, fe_n;
  // ----
  // Clock, design and memory
  // ----
  // Inverts the clock every half period
  always #25 CLK = ~CLK;
  edx_access DUT (.CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .EXT_ADDR(xa),
    .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_DOUT(xo), .EXT_DOE(doe),
    .EXT_DIN(xi), .CLOCK_STATE(cs), .FETCH_CYCLE(fetch),
    .CPU_HOLD(hold));
  edx_xmem_model u_mem (.clk(CLK), .slow(slow), .addr(xa), .rd_n(rd_n),
    .wr_n(wr_n), .wdata(xo), .doe(doe), .rdata(xi));
  // Counts strobe, hold and fetch clocks on settled values
  always @(negedge CLK) begin
    if (!rd_n || !wr_n) begin
      st_n++;
      ad_q = xa;
    end
    if (hold) ho_n++;
    if (fetch) fe_n++;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, ix};
    dw <= d;
    // Request stands until ack is sampled high; the watchdog ends a hang
    do begin
      @(posedge CLK);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Starts one transfer and polls the busy flag until it clears
  task automatic xfer(input logic [2:0] c, input logic [7:0] d);
    bus(1'b1, 8'hf1, {24'h0, d}, sc);
    st_n = 0;
    ho_n = 0;
    fe_n = 0;
    bus(1'b1, 8'hf0, {29'h0, c}, sc);
    do begin
      bus(1'b0, 8'hf2, 32'h0, sc);
    end while (sc[0] !== 1'b0);
    rb = sc[15:8];
  endtask
  task tally_and_finish;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  // Allows about seven times the expected run of about 800 clocks
  initial begin
    repeat (6000) @(posedge CLK);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, rix[i], 32'h0, sc);
      chk("reset value", sc, rvl[i]);
    end
    bus(1'b1, 8'h86, 32'hff, sc);
    bus(1'b0, 8'h86, 32'h0, sc);
    chk("select bits", sc, 32'h1);
    bus(1'b1, 8'h40, 32'hab, sc);
    bus(1'b0, 8'h40, 32'h0, sc);
    chk("unmapped read", sc, 32'h0);
    // Indirect write via bank 2 work reg 1 at the reset stretch
    bus(1'b1, 8'hd0, 32'h10, sc);
    bus(1'b1, 8'h11, 32'h77, sc);
    bus(1'b1, 8'ha0, 32'h6b, sc);
    xfer(3'h5, 8'hc3);
    chk("indirect addr", ad_q, 16'h6b77);
    chk("default hold", ho_n, 32'h8);
    bus(1'b1, 8'h86, 32'h0, sc);
    bus(1'b1, 8'h82, 32'h6b77, sc);
    xfer(3'h2, 8'h00);
    chk("indirect data", rb, 8'hc3);
    // Indirect read via bank 0 work reg 0
    bus(1'b1, 8'hd0, 32'h0, sc);
    bus(1'b1, 8'h00, 32'h77, sc);
    xfer(3'h0, 8'h00);
    chk("bank0 addr", ad_q, 16'h6b77);
    chk("bank0 data", rb, 8'hc3);
    // Every stretch: write by first pointer, read back by second
    for (int s = 0; s < 8; s++) begin
      ad = 16'ha500 | 16'(s);
      dt = 8'h5a ^ 8'(s);
      slow <= s[0];
      bus(1'b1, 8'h8e, 32'(s), sc);
      bus(1'b1, 8'h86, 32'h0, sc);
      bus(1'b1, 8'h82, {16'h0, ad}, sc);
      xfer(3'h3, dt);
      chk("pointer addr", ad_q, ad);
      chk("fetch clocks", fe_n, 32'h4);
      chk("hold clocks", ho_n, 4 * (s + 1));
      chk("strobe clocks", st_n, (s == 0) ? 2 : 4 * s);
      bus(1'b1, 8'h84, {16'h0, ad}, sc);
      bus(1'b1, 8'h86, 32'h1, sc);
      bus(1'b1, 8'h82, 32'h0, sc);
      xfer(3'h2, 8'h00);
      chk("second pointer", ad_q, ad);
      chk("read data", rb, dt);
    end
    tally_and_finish;
  end
endmodule
